// *** rtl/gsis_core.sv ***
// Bus interface state, device clear, trigger, status structure and queues
//
// Summary of operation
// RULE1 - Device clear flushes output queue and pulses clear for input path, deferred commands.
// RULE2 - Device clear leaves settings, status and enable registers untouched.
// RULE3 - Unaddressed device clear always acts, whatever the addressing.
// RULE4 - Selective device clear acts only while addressed as listener.
// RULE5 - Group trigger gives a trigger event only when bus trigger source selected.
// RULE6 - Serial poll may come anytime; the current status byte is returned.
// RULE7 - Remote sets only when addressed to listen with remote enable asserted.
// RULE8 - In remote all front-panel keys but local are ignored.
// RULE9 - Talker active on own talk address; idle on untalk, listen address, interface clear.
// RULE10 - Listener active on own listen address; idle on unlisten, talk address, interface clear.
// RULE11 - Service request holds until poll read or all causing conditions gone.
// RULE12 - Local key cancels remote unless local lockout is in effect.
// RULE13 - Condition registers are read-only and follow live status every cycle.
// RULE14 - Event bits set from condition bits and latch until cleared.
// RULE15 - Event AND enable, ORed into one summary bit feeding the status byte.
// RULE16 - Reading an event register clears it; reset and clear-status clear all.
// RULE17 - Event bit with enable zero never affects the status byte.
// RULE18 - Enable reads keep value; reset clears all; preset clears three; zero write clears.
// RULE19 - Output queue FIFO; push sets message available, empty clears it.
// RULE20 - Controller reads queued response by addressing device to talk.
// RULE21 - Error queue FIFO holds up to ten entries, each removed when read.
// RULE22 - Error push sets error available; empty error queue clears it.
// RULE23 - Status byte summary bits do not latch; they follow their sources.
// RULE24 - Serial poll resets request bit; master summary stays while summaries set.
// RULE25 - Full error queue discards new errors, keeping older ones.
`timescale 1ns/1ps
module gsis_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gsis_pkg::ADDR_W-1:0] paddr,
    input wire logic [gsis_pkg::DATA_W-1:0] pwdata,
    output logic [gsis_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoded bus messages, one-cycle pulses except busRen
    input wire logic busIfc,
    input wire logic busRen,
    input wire logic busMyListen,
    input wire logic busMyTalk,
    input wire logic busUnlisten,
    input wire logic busUntalk,
    input wire logic busDcl,
    input wire logic busSdc,
    input wire logic busGet,
    input wire logic busLlo,
    input wire logic busGtl,
    input wire logic busPollRead,
    // Talker byte path
    output logic [gsis_pkg::OUTQ_W-1:0] talkByte,
    output logic talkValid,
    input wire logic talkTake,
    // Status sources
    input wire gsis_pkg::gsis_set_t operCond,
    input wire gsis_pkg::gsis_set_t quesCond,
    input wire gsis_pkg::gsis_set_t measCond,
    input wire logic [gsis_pkg::STB_W-1:0] stdEventSet,
    input wire logic errPush,
    input wire logic [gsis_pkg::ERRQ_W-1:0] errCode,
    // Front panel
    input wire logic [gsis_pkg::KEY_W-1:0] keyPress,
    input wire logic localKey,
    output logic [gsis_pkg::KEY_W-1:0] keyAccepted,
    // Indicators and events
    output logic remoteIndicator,
    output logic talkerIndicator,
    output logic listenerIndicator,
    output logic srqIndicator,
    output logic [gsis_pkg::STB_W-1:0] pollByte,
    output logic triggerEvent,
    output logic deviceClear
);
    import gsis_pkg::*;

    function automatic logic [ADDR_W-1:0] setAddr(input logic [ADDR_W-1:0] base, input int idx);
        setAddr = ADDR_W'(base + idx * A_SET_STRIDE);
    endfunction

    // APB state
    logic preadyQ, preadyD, pslverrQ, pslverrD, popOkQ, popOkD;
    logic [DATA_W-1:0] prdataQ, prdataD;
    logic setup, access, wrStb, rdStb, clsStb, presetStb, mapped;
    // Interface state
    logic remoteQ, remoteD, talkerQ, talkerD, listenerQ, listenerD, lockoutQ, lockoutD;
    logic trigBusQ, trigBusD, devClearQ, devClearD, triggerQ, triggerD;
    logic [KEY_W-1:0] keyAccQ, keyAccD;
    // Status structure
    gsis_set_t condIn [NSETS];
    gsis_set_t condQ [NSETS];
    gsis_set_t condD [NSETS];
    gsis_set_t evtQ [NSETS];
    gsis_set_t evtD [NSETS];
    gsis_set_t enaQ [NSETS];
    gsis_set_t enaD [NSETS];
    logic [NSETS-1:0] setSum;
    gsis_stb_t esrQ, esrD, eseQ, eseD, sreQ, sreD, stbQ, stbD, prevEnQ, prevEnD, pollQ, pollD;
    gsis_stb_t enabledNow;
    logic rqsQ, rqsD, mssQ, mssD, rising;
    // Queues
    logic [ERRQ_W-1:0] errMemQ [ERRQ_DEPTH];
    logic [ERRQ_W-1:0] errMemD [ERRQ_DEPTH];
    logic [ERRQ_PTR_W-1:0] errRdQ, errRdD, errWrQ, errWrD;
    logic [CNT_W-1:0] errCntQ, errCntD, outCntQ, outCntD;
    logic [OUTQ_W-1:0] outMemQ [OUTQ_DEPTH];
    logic [OUTQ_W-1:0] outMemD [OUTQ_DEPTH];
    logic [OUTQ_PTR_W-1:0] outRdQ, outRdD, outWrQ, outWrD;
    logic [OUTQ_W-1:0] talkByteQ, talkByteD;
    logic talkValidQ, talkValidD, errPop, errAccept, outPush, outPop;

    assign setup = psel & ~penable;
    assign access = psel & penable & preadyQ;
    assign wrStb = access & pwrite;
    assign rdStb = access & ~pwrite;
    assign clsStb = wrStb && (paddr == A_CTRL) && pwdata[CTRL_CLS];
    assign presetStb = wrStb && (paddr == A_CTRL) && pwdata[CTRL_PRESET];

    assign condIn[SET_OPER] = operCond;
    assign condIn[SET_QUES] = quesCond;
    assign condIn[SET_MEAS] = measCond;

    // Address decode and read mux, captured in the setup cycle
    always_comb begin
        mapped = (paddr == A_STB) || (paddr == A_SRE) || (paddr == A_ESR) || (paddr == A_ESE) ||
                 (paddr == A_CTRL) || (paddr == A_ERRQ) || (paddr == A_OUTQ) || (paddr == A_IFST);
        prdataD = RST_WORD;
        for (int i = 0; i < NSETS; i++) begin
            if (paddr == setAddr(A_COND_BASE, i)) begin
                mapped = 1'b1;
                prdataD[SET_W-1:0] = condQ[i];
            end
            if (paddr == setAddr(A_EVT_BASE, i)) begin
                mapped = 1'b1;
                prdataD[SET_W-1:0] = evtQ[i];
            end
            if (paddr == setAddr(A_ENA_BASE, i)) begin
                mapped = 1'b1;
                prdataD[SET_W-1:0] = enaQ[i];
            end
        end
        case (paddr)
            A_STB: begin
                prdataD[STB_W-1:0] = (stbQ & STB_SUM_MASK) | (gsis_stb_t'(mssQ) << STB_RQS);
            end
            A_SRE: prdataD[STB_W-1:0] = sreQ;
            A_ESR: prdataD[STB_W-1:0] = esrQ;
            A_ESE: prdataD[STB_W-1:0] = eseQ;
            A_CTRL: prdataD[CTRL_TRIGBUS] = trigBusQ;
            A_ERRQ: prdataD[ERRQ_W-1:0] = (errCntQ != '0) ? errMemQ[errRdQ] : '0;
            A_IFST: begin
                prdataD[IF_REMOTE] = remoteQ;
                prdataD[IF_TALK] = talkerQ;
                prdataD[IF_LISTEN] = listenerQ;
                prdataD[IF_LOCKOUT] = lockoutQ;
                prdataD[IF_SRQ] = rqsQ;
                prdataD[IF_ERRCNT_LSB +: CNT_W] = errCntQ;
                prdataD[IF_OUTCNT_LSB +: CNT_W] = outCntQ;
            end
            default: ;
        endcase
        if (!setup || pwrite) begin
            prdataD = RST_WORD;
        end
        preadyD = setup;
        pslverrD = setup && !mapped;
        popOkD = setup && !pwrite && (paddr == A_ERRQ) && (errCntQ != '0);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            preadyQ <= 1'b0;
            pslverrQ <= 1'b0;
            prdataQ <= 32'h0000_0000;
            popOkQ <= 1'b0;
        end else begin
            preadyQ <= preadyD;
            pslverrQ <= pslverrD;
            popOkQ <= popOkD;
            if (setup) begin
                prdataQ <= prdataD;
            end
        end
    end

    // Interface state, clear and trigger
    always_comb begin
        talkerD = talkerQ;
        if (busMyTalk) talkerD = 1'b1; // RULE9
        if (busUntalk || busMyListen || busIfc) talkerD = 1'b0; // RULE9
        listenerD = listenerQ;
        if (busMyListen) listenerD = 1'b1; // RULE10
        if (busUnlisten || busMyTalk || busIfc) listenerD = 1'b0; // RULE10
        lockoutD = lockoutQ;
        if (busLlo) lockoutD = 1'b1;
        if (!busRen) lockoutD = 1'b0;
        remoteD = remoteQ;
        if (busRen && busMyListen) remoteD = 1'b1; // RULE7
        if (busGtl && listenerQ) remoteD = 1'b0;
        if (localKey && !lockoutQ) remoteD = 1'b0; // RULE12
        if (!busRen) remoteD = 1'b0;
        keyAccD = remoteQ ? '0 : keyPress; // RULE8
        devClearD = busDcl || (busSdc && listenerQ); // RULE3 RULE4
        triggerD = busGet && listenerQ && trigBusQ; // RULE5
        trigBusD = trigBusQ;
        if (wrStb && (paddr == A_CTRL)) trigBusD = pwdata[CTRL_TRIGBUS];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            talkerQ <= 1'b0;
            listenerQ <= 1'b0;
            lockoutQ <= 1'b0;
            remoteQ <= 1'b0;
            keyAccQ <= 8'h00;
            devClearQ <= 1'b0;
            triggerQ <= 1'b0;
            trigBusQ <= 1'b0;
        end else begin
            talkerQ <= talkerD;
            listenerQ <= listenerD;
            lockoutQ <= lockoutD;
            remoteQ <= remoteD;
            keyAccQ <= keyAccD;
            devClearQ <= devClearD;
            triggerQ <= triggerD;
            trigBusQ <= trigBusD;
        end
    end

    // Condition, event and enable sets; device clear does not reach them
    for (genvar g = 0; g < NSETS; g++) begin : gSet
        always_comb begin
            condD[g] = condIn[g]; // RULE13
            evtD[g] = evtQ[g]; // RULE2
            // Only bits actually returned are cleared; late sets survive
            if (rdStb && (paddr == setAddr(A_EVT_BASE, g))) evtD[g] = evtQ[g] & ~prdataQ[SET_W-1:0]; // RULE16
            if (clsStb) evtD[g] = '0; // RULE16
            evtD[g] = evtD[g] | condQ[g]; // RULE14
            enaD[g] = enaQ[g];
            if (wrStb && (paddr == setAddr(A_ENA_BASE, g))) enaD[g] = pwdata[SET_W-1:0]; // RULE18
            if (presetStb) enaD[g] = '0; // RULE18
            setSum[g] = |(evtQ[g] & enaQ[g]); // RULE15 RULE17
        end

        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                condQ[g] <= 16'h0000;
                evtQ[g] <= 16'h0000;
                enaQ[g] <= 16'h0000;
            end else begin
                condQ[g] <= condD[g];
                evtQ[g] <= evtD[g];
                enaQ[g] <= enaD[g];
            end
        end
    end

    // Standard event set, status byte and service request
    always_comb begin
        esrD = esrQ;
        if (rdStb && (paddr == A_ESR)) esrD = esrQ & ~prdataQ[STB_W-1:0]; // RULE16
        if (clsStb) esrD = '0;
        esrD = esrD | stdEventSet;
        eseD = eseQ;
        if (wrStb && (paddr == A_ESE)) eseD = pwdata[STB_W-1:0]; // RULE18
        sreD = sreQ;
        if (wrStb && (paddr == A_SRE)) sreD = pwdata[STB_W-1:0] & STB_SUM_MASK;
        stbD = '0; // RULE23
        stbD[STB_MEAS] = setSum[SET_MEAS];
        stbD[STB_EAV] = errCntQ != '0; // RULE22
        stbD[STB_QUES] = setSum[SET_QUES];
        stbD[STB_MAV] = outCntQ != '0; // RULE19
        stbD[STB_ESB] = |(esrQ & eseQ); // RULE15
        stbD[STB_OPER] = setSum[SET_OPER];
        enabledNow = stbQ & sreQ;
        prevEnD = enabledNow;
        rising = |(enabledNow & ~prevEnQ);
        mssD = |enabledNow; // RULE24
        rqsD = rqsQ;
        if (busPollRead || !(|enabledNow)) rqsD = 1'b0; // RULE11 RULE24
        if (rising) rqsD = 1'b1;
        pollD = (stbQ & STB_SUM_MASK) | (gsis_stb_t'(rqsD) << STB_RQS); // RULE6
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            esrQ <= 8'h00;
            eseQ <= 8'h00;
            sreQ <= 8'h00;
            stbQ <= 8'h00;
            prevEnQ <= 8'h00;
            mssQ <= 1'b0;
            rqsQ <= 1'b0;
            pollQ <= 8'h00;
        end else begin
            esrQ <= esrD;
            eseQ <= eseD;
            sreQ <= sreD;
            stbQ <= stbD;
            prevEnQ <= prevEnD;
            mssQ <= mssD;
            rqsQ <= rqsD;
            pollQ <= pollD;
        end
    end

    // Error queue and output queue
    always_comb begin
        errPop = rdStb && (paddr == A_ERRQ) && popOkQ; // RULE21
        errAccept = errPush && ((errCntQ != CNT_W'(ERRQ_DEPTH)) || errPop); // RULE25
        errMemD = errMemQ;
        errRdD = errRdQ;
        errWrD = errWrQ;
        errCntD = errCntQ;
        if (errAccept) begin
            errMemD[errWrQ] = errCode;
            errWrD = (errWrQ == ERRQ_PTR_W'(ERRQ_DEPTH - 1)) ? '0 : errWrQ + 1'b1;
        end
        if (errPop) begin
            errRdD = (errRdQ == ERRQ_PTR_W'(ERRQ_DEPTH - 1)) ? '0 : errRdQ + 1'b1;
        end
        errCntD = errCntQ + CNT_W'(errAccept) - CNT_W'(errPop);
        outPush = wrStb && (paddr == A_OUTQ) && (outCntQ != CNT_W'(OUTQ_DEPTH));
        outPop = talkTake && talkValidQ; // RULE20
        outMemD = outMemQ;
        outRdD = outRdQ + OUTQ_PTR_W'(outPop);
        outWrD = outWrQ;
        if (outPush) begin
            outMemD[outWrQ] = pwdata[OUTQ_W-1:0]; // RULE19
            outWrD = outWrQ + 1'b1;
        end
        outCntD = outCntQ + CNT_W'(outPush) - CNT_W'(outPop);
        if (devClearQ) begin
            outRdD = '0; // RULE1
            outWrD = '0;
            outCntD = '0;
        end
        talkValidD = (outCntD != '0) && talkerD;
        talkByteD = outMemD[outRdD];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ERRQ_DEPTH; i++) errMemQ[i] <= 16'h0000;
            for (int i = 0; i < OUTQ_DEPTH; i++) outMemQ[i] <= 8'h00;
            errRdQ <= 4'h0;
            errWrQ <= 4'h0;
            errCntQ <= 4'h0;
            outRdQ <= 3'h0;
            outWrQ <= 3'h0;
            outCntQ <= 4'h0;
            talkValidQ <= 1'b0;
            talkByteQ <= 8'h00;
        end else begin
            errMemQ <= errMemD;
            outMemQ <= outMemD;
            errRdQ <= errRdD;
            errWrQ <= errWrD;
            errCntQ <= errCntD;
            outRdQ <= outRdD;
            outWrQ <= outWrD;
            outCntQ <= outCntD;
            talkValidQ <= talkValidD;
            talkByteQ <= talkByteD;
        end
    end

    assign prdata = prdataQ;
    assign pready = preadyQ;
    assign pslverr = pslverrQ;
    assign talkByte = talkByteQ;
    assign talkValid = talkValidQ;
    assign keyAccepted = keyAccQ;
    assign remoteIndicator = remoteQ;
    assign talkerIndicator = talkerQ;
    assign listenerIndicator = listenerQ;
    assign srqIndicator = rqsQ;
    assign pollByte = pollQ;
    assign triggerEvent = triggerQ;
    assign deviceClear = devClearQ;

    // Checks
    sequence s_talkOnly;
        busMyTalk && !busUntalk && !busMyListen && !busIfc;
    endsequence
    sequence s_talkDrop;
        busUntalk || busMyListen || busIfc;
    endsequence
    property p_talker;
        @(posedge core_clk) disable iff (!reset_n) (s_talkOnly |=> talkerQ) and (s_talkDrop |=> !talkerQ);
    endproperty
    a_talker: assert property (p_talker) else $error("talker state wrong"); // RULE9
    property p_listener;
        @(posedge core_clk) disable iff (!reset_n) (busUnlisten || busMyTalk || busIfc) |=> !listenerQ;
    endproperty
    a_listener: assert property (p_listener) else $error("listener not idled"); // RULE10
    property p_remoteCause;
        @(posedge core_clk) disable iff (!reset_n) $rose(remoteQ) |-> $past(busRen && busMyListen);
    endproperty
    a_remoteCause: assert property (p_remoteCause) else $error("remote set without listen address"); // RULE7
    property p_keysLocked;
        @(posedge core_clk) disable iff (!reset_n) remoteQ |=> (keyAccQ == '0);
    endproperty
    a_keysLocked: assert property (p_keysLocked) else $error("key passed in remote"); // RULE8
    property p_localKey;
        @(posedge core_clk) disable iff (!reset_n) (localKey && !lockoutQ) |=> !remoteQ;
    endproperty
    a_localKey: assert property (p_localKey) else $error("local key did not cancel remote"); // RULE12
    property p_dclFlush;
        @(posedge core_clk) disable iff (!reset_n) busDcl |=> devClearQ ##1 (outCntQ == '0);
    endproperty
    a_dclFlush: assert property (p_dclFlush) else $error("device clear did not flush"); // RULE3
    property p_sdcGate;
        @(posedge core_clk) disable iff (!reset_n) (busSdc && !busDcl && !listenerQ) |=> !devClearQ;
    endproperty
    a_sdcGate: assert property (p_sdcGate) else $error("selective clear while unaddressed"); // RULE4
    property p_getGate;
        @(posedge core_clk) disable iff (!reset_n) (busGet && !trigBusQ) |=> !triggerQ;
    endproperty
    a_getGate: assert property (p_getGate) else $error("trigger without bus source"); // RULE5
    property p_pollClears;
        @(posedge core_clk) disable iff (!reset_n) (busPollRead && !rising) |=> !rqsQ ##1 !pollQ[STB_RQS];
    endproperty
    a_pollClears: assert property (p_pollClears) else $error("poll left request bit"); // RULE24
    property p_errBound;
        @(posedge core_clk) disable iff (!reset_n) errCntQ <= CNT_W'(ERRQ_DEPTH);
    endproperty
    a_errBound: assert property (p_errBound) else $error("error queue overfilled"); // RULE21
    property p_errAvail;
        @(posedge core_clk) disable iff (!reset_n) (errCntQ != '0) |=> stbQ[STB_EAV] || $past(errPop);
    endproperty
    a_errAvail: assert property (p_errAvail) else $error("error available not shown"); // RULE22
endmodule

// *** rtl/gsis_pkg.sv ***
// Constants, register map and types for the bus status and interface state block
package gsis_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SET_W = 16;
    localparam int NSETS = 3;
    localparam int STB_W = 8;
    localparam int KEY_W = 8;
    localparam int ERRQ_DEPTH = 10;
    localparam int ERRQ_W = 16;
    localparam int ERRQ_PTR_W = 4;
    localparam int OUTQ_DEPTH = 8;
    localparam int OUTQ_W = 8;
    localparam int OUTQ_PTR_W = 3;
    localparam int CNT_W = 4;

    typedef logic [SET_W-1:0] gsis_set_t;
    typedef logic [STB_W-1:0] gsis_stb_t;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] A_STB = 8'h00;
    localparam logic [ADDR_W-1:0] A_SRE = 8'h04;
    localparam logic [ADDR_W-1:0] A_ESR = 8'h08;
    localparam logic [ADDR_W-1:0] A_ESE = 8'h0C;
    localparam logic [ADDR_W-1:0] A_COND_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] A_EVT_BASE = 8'h14;
    localparam logic [ADDR_W-1:0] A_ENA_BASE = 8'h18;
    localparam logic [ADDR_W-1:0] A_SET_STRIDE = 8'h0C;
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h34;
    localparam logic [ADDR_W-1:0] A_ERRQ = 8'h38;
    localparam logic [ADDR_W-1:0] A_OUTQ = 8'h3C;
    localparam logic [ADDR_W-1:0] A_IFST = 8'h40;

    // Set indices
    localparam int SET_OPER = 0;
    localparam int SET_QUES = 1;
    localparam int SET_MEAS = 2;
    localparam int OPER_MEAS_BIT = 4;

    // Control register bits
    localparam int CTRL_CLS = 0;
    localparam int CTRL_PRESET = 1;
    localparam int CTRL_TRIGBUS = 2;

    // Interface state register fields
    localparam int IF_REMOTE = 0;
    localparam int IF_TALK = 1;
    localparam int IF_LISTEN = 2;
    localparam int IF_LOCKOUT = 3;
    localparam int IF_SRQ = 4;
    localparam int IF_ERRCNT_LSB = 8;
    localparam int IF_OUTCNT_LSB = 12;

    // Status byte positions
    localparam int STB_MEAS = 0;
    localparam int STB_EAV = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OPER = 7;
    localparam gsis_stb_t STB_SUM_MASK = 8'hBD;

    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
endpackage

// *** tb/gsis_bus_ctrl.sv ***
// Bus controller model: addresses, clears, triggers and polls the device
`timescale 1ns/1ps
module gsis_bus_ctrl (
    // Clock
    input wire logic core_clk,
    // Messages as one-hot pulses, remote enable level, talker handshake
    output logic [10:0] busMsg,
    output logic busRen,
    output logic talkTake,
    // Device answers
    input wire logic [7:0] pollByte,
    input wire logic [7:0] talkByte,
    input wire logic talkValid
);
    initial begin
        busMsg = '0;
        busRen = 1'b0;
        talkTake = 1'b0;
    end
    task automatic ren(input logic v);
        busRen <= v;
    endtask
    task automatic send(input int k);
        @(posedge core_clk);
        busMsg <= 11'h001 << k;
        @(posedge core_clk);
        busMsg <= '0;
    endtask
    // Poll allowed at any moment; byte taken before the poll goes out
    task automatic poll(output logic [7:0] b);
        b = pollByte;
        send(10);
    endtask
    // Response fetched by addressing to talk, then one byte consumed
    task automatic take(output logic [7:0] b);
        send(2);
        repeat (3) @(posedge core_clk);
        b = talkByte;
        talkTake <= 1'b1;
        @(posedge core_clk);
        talkTake <= 1'b0;
    endtask
endmodule

// *** tb/tb_gsis_core.sv ***
// Self-checking bench for the bus status and interface state block
`timescale 1ns/1ps
module tb_gsis_core;
    import gsis_pkg::*;
    logic core_clk, reset_n, psel, penable, pwrite;
    logic errPush, localKey;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic pready, pslverr, talkTake, talkValid, busRen, remoteIndicator, talkerIndicator, listenerIndicator;
    logic srqIndicator, triggerEvent, deviceClear;
    logic [ERRQ_W-1:0] errCode;
    logic [KEY_W-1:0] keyPress, keyAccepted;
    logic [7:0] talkByte, pollByte, sb;
    logic [10:0] busMsg;
    gsis_set_t operCond, quesCond, measCond;
    logic [STB_W-1:0] stdEventSet;
    int errCount = 0, totalChecks = 0;
    always #2 core_clk = ~core_clk;
    gsis_bus_ctrl bc (.*);
    // Message index: 0 clear 1 listen 2 talk 3 unlisten 4 untalk 5 all-clear 6 sel-clear 7 trig 8 lockout 9 local
    gsis_core gsis_core_i (.*, .busIfc(busMsg[0]), .busMyListen(busMsg[1]), .busMyTalk(busMsg[2]),
        .busUnlisten(busMsg[3]), .busUntalk(busMsg[4]), .busDcl(busMsg[5]), .busSdc(busMsg[6]), .busGet(busMsg[7]),
        .busLlo(busMsg[8]), .busGtl(busMsg[9]), .busPollRead(busMsg[10]));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(rd, exp, $sformatf("reg %0h", a));
    endtask
    task automatic drive(input logic [7:0] k, input logic l, input logic e, input logic [15:0] c);
        @(posedge core_clk);
        keyPress <= k;
        localKey <= l;
        errPush <= e;
        errCode <= c;
        @(posedge core_clk);
        keyPress <= '0;
        localKey <= 1'b0;
        errPush <= 1'b0;
    endtask
    task automatic t_addr();
        bc.ren(1'b1);
        tick(3);
        chk(remoteIndicator, 0, "remote");
        bc.send(1);
        drive(8'h0F, 0, 0, '0);
        tick(1);
        chk({remoteIndicator, listenerIndicator, keyAccepted}, 10'h300, "keys in remote");
        drive(8'h00, 1, 0, '0);
        drive(8'h0F, 0, 0, '0);
        tick(1);
        chk({remoteIndicator, keyAccepted}, 9'h00F, "local key");
        bc.send(1);
        bc.send(8);
        drive(8'h00, 1, 0, '0);
        tick(1);
        chk(remoteIndicator, 1, "lockout");
        bc.send(9);
        tick(1);
        chk(remoteIndicator, 0, "go to local");
        bc.send(2);
        tick(1);
        chk({talkerIndicator, listenerIndicator}, 2'b10, "talk");
        bc.send(1);
        tick(1);
        chk({talkerIndicator, listenerIndicator}, 2'b01, "listen");
        bc.send(3);
        bc.send(2);
        bc.send(4);
        bc.send(1);
        bc.send(0);
        tick(1);
        chk({talkerIndicator, listenerIndicator}, 2'b00, "idle");
        $display("addressing test done");
    endtask
    task automatic t_queues();
        apb(1'b1, A_ESE, 32'h0000_0020);
        apb(1'b1, A_OUTQ, 32'h0000_00A5);
        tick(3);
        apb(1'b0, A_STB, '0);
        chk(rd[STB_MAV], 1, "msg avail");
        bc.take(sb);
        tick(3);
        apb(1'b0, A_STB, '0);
        chk({sb, rd[STB_MAV]}, 9'h14A, "talk byte");
        apb(1'b1, A_OUTQ, 32'h0000_005A);
        bc.send(6);
        apb(1'b0, A_IFST, '0);
        chk(rd[15:12], 1, "sel clear ignored");
        bc.send(5);
        tick(1);
        chk(deviceClear, 1, "clear pulse");
        tick(1);
        chk(talkValid, 0, "queue flushed");
        rdx(A_ESE, 32'h0000_0020);
        bc.send(1);
        bc.send(6);
        tick(1);
        chk(deviceClear, 1, "sel clear");
        for (int i = 0; i < 11; i++) begin
            drive(8'h00, 0, 1, 16'(256 + i));
        end
        tick(3);
        apb(1'b0, A_IFST, '0);
        chk(rd[11:8], 10, "err count");
        for (int i = 0; i < 11; i++) begin
            rdx(A_ERRQ, i < 10 ? 32'(256 + i) : '0);
        end
        tick(3);
        apb(1'b0, A_STB, '0);
        chk(rd[STB_EAV], 0, "err empty");
        $display("queue test done");
    endtask
    task automatic t_status();
        apb(1'b1, A_SRE, 32'h0000_0080);
        apb(1'b1, A_ENA_BASE + A_SET_STRIDE, 32'h0000_0002);
        operCond <= 16'h0010;
        quesCond <= 16'h0002;
        measCond <= 16'h0004;
        stdEventSet <= 8'h20;
        tick(6);
        rdx(A_COND_BASE, 32'h0000_0010);
        apb(1'b0, A_STB, '0);
        chk(rd[STB_OPER], 0, "masked");
        chk(rd[7:0], 8'h28, "summaries");
        operCond <= '0;
        stdEventSet <= '0;
        apb(1'b1, A_ENA_BASE, 32'h0000_0010);
        tick(6);
        chk({srqIndicator, pollByte[STB_RQS], pollByte[STB_OPER]}, 3'b111, "request");
        rdx(A_COND_BASE, '0);
        rdx(A_ENA_BASE, 32'h0000_0010);
        rdx(A_ESR, 32'h0000_0020);
        rdx(A_ESR, '0);
        bc.poll(sb);
        tick(3);
        chk({sb[STB_RQS], srqIndicator, pollByte[STB_RQS]}, 3'b100, "poll");
        apb(1'b0, A_STB, '0);
        chk(rd[7:6], 2'b11, "summary kept");
        rdx(A_EVT_BASE, 32'h0000_0010);
        rdx(A_EVT_BASE, '0);
        tick(3);
        apb(1'b0, A_STB, '0);
        chk(rd[7:6], 2'b00, "summary follows");
        apb(1'b1, A_CTRL, 32'h0000_0002);
        apb(1'b1, A_ESE, '0);
        rdx(A_ENA_BASE, '0);
        rdx(A_ENA_BASE + A_SET_STRIDE, '0);
        rdx(A_ESE, '0);
        bc.send(7);
        tick(1);
        chk(triggerEvent, 0, "trigger ignored");
        apb(1'b1, A_CTRL, 32'h0000_0004);
        bc.send(7);
        tick(1);
        chk(triggerEvent, 1, "trigger");
        $display("status test done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        {psel, penable, pwrite, errPush, localKey, paddr, pwdata, errCode, keyPress} = '0;
        {operCond, quesCond, measCond, stdEventSet} = '0;
        tick(20);
        reset_n <= 1'b1;
        apb(1'b0, 8'hFC, '0);
        chk({pslverr, rd}, 33'h1_0000_0000, "unmapped");
        t_addr();
        t_queues();
        t_status();
        test_done();
    end
    initial begin
        #100000;
        errCount++;
        test_done();
    end
endmodule
